/* File: design/caf_pkg.sv */
// =============================================================================
// Acceptance filter package
package caf_pkg;

   // =============================================================================
   // Sizes
   localparam int NUM_FILTERS = 16;
   localparam int NUM_MASKS = 3;
   localparam int FIDX_W = 4;
   localparam int APB_AW = 12;
   localparam int REG_W = 16;

   // =============================================================================
   // Identifier register field layout
   localparam int SID_MSB = 15;
   localparam int SID_LSB = 5;
   localparam int TYPE_BIT = 3;
   localparam int EXT_HI_MSB = 1;
   localparam int EXT_HI_LSB = 0;
   localparam int SID_W = 11;
   localparam int EID_W = 18;
   localparam logic [15:0] STD_IMPL_MASK = 16'hFFEB;

   // =============================================================================
   // Mask source codes and buffer pointer codes
   localparam logic [1:0] MSK_SRC_0 = 2'h0;
   localparam logic [1:0] MSK_SRC_1 = 2'h1;
   localparam logic [1:0] MSK_SRC_2 = 2'h2;
   localparam logic [3:0] BUF_TO_FIFO = 4'hF;

   // =============================================================================
   // Register byte offsets
   localparam logic [11:0] ADDR_FILT_BASE = 12'h000;
   localparam logic [11:0] ADDR_FILT_LAST = 12'h07C;
   localparam logic [11:0] ADDR_MSEL_LOW = 12'h080;
   localparam logic [11:0] ADDR_MSEL_HIGH = 12'h084;
   localparam logic [11:0] ADDR_MASK_BASE = 12'h090;
   localparam logic [11:0] ADDR_MASK_LAST = 12'h0A4;
   localparam logic [11:0] ADDR_STATUS = 12'h0A8;

   // =============================================================================
   // Reset values
   localparam logic [15:0] MSEL_RST = 16'h0000;
   localparam logic [15:0] MASK_RST = 16'h0000;

   // =============================================================================
   // Status register fields
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_HIT_BIT = 1;
   localparam int ST_FILT_LSB = 4;
   localparam int ST_BUF_LSB = 8;

   // Controller states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SCAN = 3'b010,
      ST_APBR = 3'b100
   } caf_state_type;

endpackage

/* File: design/caf_filter_mem.sv */
`timescale 1ns/1ps
// =============================================================================
// Filter identifier storage, one word per filter, registered read data
module caf_filter_mem #(
   parameter int AW = 4,
   parameter int LANE_W = 16,
   parameter int LANES = 2
) (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic [AW-1:0] waddr,
   input wire logic [LANES-1:0] wlane,
   input wire logic [LANE_W-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [LANES*LANE_W-1:0] rdata
);

   logic [LANES*LANE_W-1:0] mem [0:(1<<AW)-1];

   // Lane-wise write keeps the other half of the word intact
   always_ff @(posedge clk)
   begin
      for (int l = 0; l < LANES; l++)
      begin
         if (wlane[l])
         begin
            mem[waddr][l*LANE_W +: LANE_W] <= wdata;
         end
      end
   end

   // Read data from a register; no reset, contents start unknown
   always_ff @(posedge clk)
   begin
      rdata <= mem[raddr];
   end

endmodule

/* File: design/caf_top.sv */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// =============================================================================
// Summary of operation
// - Included standard id bits must equal filter
// - Included extended id bits must equal filter
// - Type match: select 1 extended, 0 standard
// - No type match: either frame type accepted
// - Type match accepts only filter's chosen type
// - Standard mask bit 1 compares, 0 ignores
// - Eighteen extended mask bits compare or ignore
// - Mask source 00/01/10 picks mask 0/1/2
// - Filters 0-7 sources in low select register
// - Filters 8-15 sources in high select register
// - Sixteen independent filters with own id registers
// - Standard id bits 4 and 2 read zero
// - Only enabled filters may accept frames
// - Hit routes to filter's buffer; 1111 is FIFO
module caf_top
   import caf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Adjoining enable and pointer registers
   input wire logic [NUM_FILTERS-1:0] filter_enable_bit,
   input wire logic [4*NUM_FILTERS-1:0] filter_buffer_pointer,
   // Received frame
   input wire logic frm_valid,
   input wire logic [SID_W-1:0] frm_std_id,
   input wire logic [EID_W-1:0] frm_ext_id,
   input wire logic frm_is_ext,
   output logic frm_ready,
   // Acceptance result
   output logic acc_valid,
   output logic acc_hit,
   output logic [FIDX_W-1:0] acc_filter,
   output logic [3:0] acc_buffer,
   output logic acc_to_fifo
);

   // =============================================================================
   // Functions
   // Unimplemented bits of a standard id register are forced to zero
   function automatic logic [15:0] std_clean(input logic [15:0] v);
      std_clean = v & STD_IMPL_MASK;
   endfunction

   // One filter against one frame under one mask
   function automatic logic id_match(
      input logic [15:0] fstd,
      input logic [15:0] fext,
      input logic [15:0] mstd,
      input logic [15:0] mext,
      input logic [SID_W-1:0] sid,
      input logic [EID_W-1:0] eid,
      input logic is_ext
   );
      logic [SID_W-1:0] sid_diff;
      logic [EID_W-1:0] eid_diff;
      logic type_ok;
      sid_diff = (fstd[SID_MSB:SID_LSB] ^ sid) & mstd[SID_MSB:SID_LSB];
      eid_diff = ({fstd[EXT_HI_MSB:EXT_HI_LSB], fext} ^ eid)
                 & {mstd[EXT_HI_MSB:EXT_HI_LSB], mext};
      // Type condition only when the mask asks for it
      type_ok = mstd[TYPE_BIT] ? (fstd[TYPE_BIT] == is_ext) : 1'b1;
      // A standard frame carries no extended bits, so only its SID is compared
      id_match = type_ok && (sid_diff == '0) && (!is_ext || (eid_diff == '0));
   endfunction

   // =============================================================================
   // State
   caf_state_type state_q, state_d;
   logic [FIDX_W-1:0] eval_idx_q;
   logic [SID_W-1:0] sid_q;
   logic [EID_W-1:0] eid_q;
   logic is_ext_q;
   logic [15:0] msel_low_q;
   logic [15:0] msel_high_q;
   logic [15:0] mask_std_q [0:NUM_MASKS-1];
   logic [15:0] mask_ext_q [0:NUM_MASKS-1];
   logic last_hit_q;
   logic [FIDX_W-1:0] last_filt_q;
   logic [3:0] last_buf_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic frm_ready_q;
   logic acc_valid_q;
   logic acc_hit_q;
   logic [FIDX_W-1:0] acc_filter_q;
   logic [3:0] acc_buffer_q;
   logic acc_to_fifo_q;
   logic [31:0] mem_rdata;

   // =============================================================================
   // APB decode
   wire logic acc_pend_w = psel && penable && !pready_q;
   wire logic fire_w = psel && penable && pready_q;
   wire logic aligned_w = (paddr[1:0] == 2'h0);
   wire logic is_filt_w = aligned_w && (paddr <= ADDR_FILT_LAST);
   wire logic is_msel_lo_w = (paddr == ADDR_MSEL_LOW);
   wire logic is_msel_hi_w = (paddr == ADDR_MSEL_HIGH);
   wire logic is_mask_w = aligned_w && (paddr >= ADDR_MASK_BASE) && (paddr <= ADDR_MASK_LAST);
   wire logic is_status_w = (paddr == ADDR_STATUS);
   wire logic mapped_w = is_filt_w || is_msel_lo_w || is_msel_hi_w || is_mask_w || is_status_w;
   wire logic [FIDX_W-1:0] apb_fidx_w = paddr[6:3];
   wire logic [11:0] mask_off_w = paddr - ADDR_MASK_BASE;
   wire logic [1:0] mask_idx_w = mask_off_w[4:3];
   wire logic half_ext_w = paddr[2];
   wire logic [15:0] wdata16_w = pwdata[15:0];
   wire logic wr_fire_w = fire_w && pwrite && !pslverr_q;
   // Filter reads go through the storage read port and must wait for it
   wire logic mem_rd_req_w = acc_pend_w && !pwrite && is_filt_w;

   // =============================================================================
   // Scan control
   wire logic start_scan_w = (state_q == ST_IDLE) && frm_valid;
   wire logic start_apbr_w = (state_q == ST_IDLE) && !frm_valid && mem_rd_req_w;
   wire logic [FIDX_W-1:0] eval_next_w = FIDX_W'(eval_idx_q + 1'b1);
   wire logic [FIDX_W-1:0] raddr_w = start_scan_w ? '0
                                   : (state_q == ST_SCAN) ? eval_next_w : apb_fidx_w;
   wire logic [31:0] msel_all_w = {msel_high_q, msel_low_q};
   wire logic [1:0] msel_w = msel_all_w[{eval_idx_q, 1'b0} +: 2];
   wire logic msel_ok_w = (msel_w == MSK_SRC_0) || (msel_w == MSK_SRC_1)
                          || (msel_w == MSK_SRC_2);
   // Reserved code 11 falls back on mask 0 index but can never produce a hit
   wire logic [1:0] mask_pick_w = msel_ok_w ? msel_w : MSK_SRC_0;
   wire logic [15:0] cur_fstd_w = std_clean(mem_rdata[15:0]);
   wire logic [15:0] cur_fext_w = mem_rdata[31:16];
   wire logic [15:0] cur_mstd_w = mask_std_q[mask_pick_w];
   wire logic [15:0] cur_mext_w = mask_ext_q[mask_pick_w];
   wire logic cur_match_w = id_match(cur_fstd_w, cur_fext_w, cur_mstd_w, cur_mext_w,
                                     sid_q, eid_q, is_ext_q);
   // Disabled filters and reserved mask codes never accept
   wire logic cur_hit_w = (state_q == ST_SCAN) && msel_ok_w
                          && filter_enable_bit[eval_idx_q] && cur_match_w;
   wire logic scan_end_w = (state_q == ST_SCAN)
                           && (cur_hit_w || (eval_idx_q == FIDX_W'(NUM_FILTERS - 1)));
   wire logic [3:0] cur_buf_w = filter_buffer_pointer[{eval_idx_q, 2'b00} +: 4];

   // =============================================================================
   // Filter storage write lanes: std half in lane 0, ext half in lane 1
   wire logic [1:0] mem_wlane_w = (wr_fire_w && is_filt_w)
                                  ? (half_ext_w ? 2'b10 : 2'b01) : 2'b00;
   wire logic [15:0] mem_wdata_w = half_ext_w ? wdata16_w : std_clean(wdata16_w);

   caf_filter_mem #(
      .AW(FIDX_W),
      .LANE_W(REG_W),
      .LANES(2)
   ) u_mem (
      .clk(pclk),
      .waddr(apb_fidx_w),
      .wlane(mem_wlane_w),
      .wdata(mem_wdata_w),
      .raddr(raddr_w),
      .rdata(mem_rdata)
   );

   // =============================================================================
   // Register read mux for flop-held registers
   wire logic [15:0] status_w = {4'h0, last_buf_q, last_filt_q, 2'b00, last_hit_q,
                                 (state_q != ST_IDLE)};
   wire logic [15:0] mask_rd_w = half_ext_w ? mask_ext_q[mask_idx_w]
                                            : std_clean(mask_std_q[mask_idx_w]);
   wire logic [15:0] reg_rd_w = is_msel_lo_w ? msel_low_q
                              : is_msel_hi_w ? msel_high_q
                              : is_mask_w ? mask_rd_w
                              : is_status_w ? status_w : 16'h0000;
   wire logic [15:0] mem_rd_w = half_ext_w ? mem_rdata[31:16] : std_clean(mem_rdata[15:0]);
   // Accesses other than filter storage reads answer with pready in the second access cycle
   wire logic fast_ans_w = acc_pend_w && !mem_rd_req_w;
   wire logic slow_ans_w = (state_q == ST_APBR);

   // =============================================================================
   // Next state
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
         begin
            if (start_scan_w)
            begin
               state_d = ST_SCAN;
            end
            else if (start_apbr_w)
            begin
               state_d = ST_APBR;
            end
         end
         ST_SCAN:
         begin
            if (scan_end_w)
            begin
               state_d = ST_IDLE;
            end
         end
         ST_APBR:
         begin
            state_d = ST_IDLE;
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // State, scan index and frame capture
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         eval_idx_q <= '0;
         sid_q <= '0;
         eid_q <= '0;
         is_ext_q <= 1'b0;
         frm_ready_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         eval_idx_q <= start_scan_w ? '0 : (state_q == ST_SCAN) ? eval_next_w : eval_idx_q;
         if (start_scan_w)
         begin
            sid_q <= frm_std_id;
            eid_q <= frm_ext_id;
            is_ext_q <= frm_is_ext;
         end
         frm_ready_q <= (state_d == ST_IDLE);
      end
   end

   // Result: lowest-numbered hitting filter wins, one pulse per frame
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_valid_q <= 1'b0;
         acc_hit_q <= 1'b0;
         acc_filter_q <= '0;
         acc_buffer_q <= '0;
         acc_to_fifo_q <= 1'b0;
         last_hit_q <= 1'b0;
         last_filt_q <= '0;
         last_buf_q <= '0;
      end
      else
      begin
         acc_valid_q <= scan_end_w;
         if (scan_end_w)
         begin
            acc_hit_q <= cur_hit_w;
            acc_filter_q <= cur_hit_w ? eval_idx_q : '0;
            acc_buffer_q <= cur_hit_w ? cur_buf_w : '0;
            acc_to_fifo_q <= cur_hit_w && (cur_buf_w == BUF_TO_FIFO);
            last_hit_q <= cur_hit_w;
            last_filt_q <= cur_hit_w ? eval_idx_q : '0;
            last_buf_q <= cur_hit_w ? cur_buf_w : '0;
         end
      end
   end

   // Mask and mask-select registers, written only at the completing edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         msel_low_q <= MSEL_RST;
         msel_high_q <= MSEL_RST;
         for (int m = 0; m < NUM_MASKS; m++)
         begin
            mask_std_q[m] <= MASK_RST;
            mask_ext_q[m] <= MASK_RST;
         end
      end
      else if (wr_fire_w)
      begin
         if (is_msel_lo_w)
         begin
            msel_low_q <= wdata16_w;
         end
         if (is_msel_hi_w)
         begin
            msel_high_q <= wdata16_w;
         end
         if (is_mask_w && half_ext_w)
         begin
            mask_ext_q[mask_idx_w] <= wdata16_w;
         end
         if (is_mask_w && !half_ext_w)
         begin
            mask_std_q[mask_idx_w] <= std_clean(wdata16_w);
         end
      end
   end

   // APB answer: ready held for exactly one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end
      else
      begin
         pready_q <= !pready_q && (fast_ans_w || slow_ans_w);
         if (fast_ans_w)
         begin
            pslverr_q <= !mapped_w;
            prdata_q <= {16'h0000, (pwrite ? 16'h0000 : reg_rd_w)};
         end
         else if (slow_ans_w)
         begin
            pslverr_q <= 1'b0;
            prdata_q <= {16'h0000, mem_rd_w};
         end
      end
   end

   // =============================================================================
   // Outputs straight from flops
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign frm_ready = frm_ready_q;
   assign acc_valid = acc_valid_q;
   assign acc_hit = acc_hit_q;
   assign acc_filter = acc_filter_q;
   assign acc_buffer = acc_buffer_q;
   assign acc_to_fifo = acc_to_fifo_q;

endmodule

/* File: bench/caf_top_asserts.sv */
`timescale 1ns/1ps
// ========================================
// Port checks for the acceptance filter
module caf_top_checker
   import caf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Register bus
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   // Filter side
   input wire logic [NUM_FILTERS-1:0] filter_enable_bit,
   input wire logic [4*NUM_FILTERS-1:0] filter_buffer_pointer,
   input wire logic frm_valid,
   input wire logic frm_ready,
   input wire logic acc_valid,
   input wire logic acc_hit,
   input wire logic [FIDX_W-1:0] acc_filter,
   input wire logic [3:0] acc_buffer,
   input wire logic acc_to_fifo
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Frame handshake and scan length
   // Filter k hit is seen k+2 edges after the taking edge, a full miss 17
   scan_bound_a: assert property (frm_valid && frm_ready |-> ##[2:17] acc_valid)
      else $error("frame result late");
   taken_busy_a: assert property (frm_valid && frm_ready |=> !frm_ready)
      else $error("frame port still ready");
   result_pulse_a: assert property (acc_valid |=> !acc_valid)
      else $error("result pulse too long");
   ready_back_a: assert property (acc_valid |-> frm_ready)
      else $error("frame port not back");
   // Results must not drift between pulses, software reads them late
   result_hold_a: assert property (!acc_valid |-> $stable({acc_hit, acc_filter, acc_buffer}))
      else $error("result moved");
   // A hit names an enabled filter and its own pointer
   enabled_hit_a: assert property (acc_valid && acc_hit |-> filter_enable_bit[acc_filter])
      else $error("hit on disabled filter");
   buffer_route_a: assert property (acc_valid && acc_hit |->
      acc_buffer == filter_buffer_pointer[4*acc_filter +: 4])
      else $error("wrong buffer");
   fifo_flag_a: assert property (acc_valid |->
      acc_to_fifo == (acc_hit && acc_buffer == BUF_TO_FIFO))
      else $error("fifo flag wrong");
   miss_zero_a: assert property (acc_valid && !acc_hit |-> acc_filter == 0 && acc_buffer == 0)
      else $error("miss not zeroed");
   // Bus answers
   apb_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   apb_access_a: assert property (pready |-> psel && penable && prdata[31:16] == 16'h0000)
      else $error("answer outside access");
   // Extended halves use all sixteen bits, so only standard words are checked
   id_gap_a: assert property (pready && !pwrite && !paddr[2] && (paddr < ADDR_MSEL_LOW ||
      (paddr >= ADDR_MASK_BASE && paddr < ADDR_STATUS)) |-> prdata[4] == 0 && prdata[2] == 0)
      else $error("unimplemented id bit set");
endmodule

bind caf_top caf_top_checker u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .filter_enable_bit(filter_enable_bit), .filter_buffer_pointer(filter_buffer_pointer),
   .frm_valid(frm_valid), .frm_ready(frm_ready), .acc_valid(acc_valid),
   .acc_hit(acc_hit), .acc_filter(acc_filter), .acc_buffer(acc_buffer),
   .acc_to_fifo(acc_to_fifo)
);

/* File: bench/caf_can_node.sv */
`timescale 1ns/1ps
// ========================================
// Remote node: offers one frame, holds it until taken
module caf_can_node
   import caf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench command
   input wire logic send,
   input wire logic [SID_W-1:0] sid,
   input wire logic [EID_W-1:0] eid,
   input wire logic ext,
   // Frame port
   input wire logic frm_ready,
   output logic frm_valid,
   output logic [SID_W-1:0] frm_std_id,
   output logic [EID_W-1:0] frm_ext_id,
   output logic frm_is_ext
);
   // Ids are inverted once taken, so a stale frame never looks held
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         frm_valid <= 1'b0;
         frm_std_id <= '0;
         frm_ext_id <= '0;
         frm_is_ext <= 1'b0;
      end
      else if (frm_valid && frm_ready)
      begin
         frm_valid <= 1'b0;
         frm_std_id <= ~frm_std_id;
         frm_ext_id <= ~frm_ext_id;
         frm_is_ext <= ~frm_is_ext;
      end
      else if (send && !frm_valid)
      begin
         frm_valid <= 1'b1;
         frm_std_id <= sid;
         frm_ext_id <= eid;
         frm_is_ext <= ext;
      end
   end
endmodule

/* File: bench/caf_top_test.sv */
`timescale 1ns/1ps
// ========================================
// Bench for the acceptance filter block
module caf_top_test
   import caf_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [15:0] en = 16'hFFFF;
   logic [63:0] bptr = 64'h0123456789ABCDEF;
   logic send = 1'b0;
   logic [10:0] sid = 11'h000;
   logic [17:0] eid = 18'h00000;
   logic ext = 1'b0;
   logic frm_valid;
   logic frm_ready;
   logic frm_is_ext;
   logic [10:0] frm_std_id;
   logic [17:0] frm_ext_id;
   logic acc_valid;
   logic acc_hit;
   logic acc_to_fifo;
   logic [3:0] acc_filter;
   logic [3:0] acc_buffer;
   logic [15:0] mf_std [16];
   logic [15:0] mf_ext [16];
   logic [15:0] mm_std [3];
   logic [15:0] mm_ext [3];
   logic [31:0] msel;
   logic [10:0] vs;
   logic [17:0] vx;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;

   // Clock
   initial
   begin
      forever #5 pclk = ~pclk;
   end

   caf_top dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .filter_enable_bit(en), .filter_buffer_pointer(bptr), .frm_valid(frm_valid),
      .frm_std_id(frm_std_id), .frm_ext_id(frm_ext_id), .frm_is_ext(frm_is_ext),
      .frm_ready(frm_ready), .acc_valid(acc_valid), .acc_hit(acc_hit),
      .acc_filter(acc_filter), .acc_buffer(acc_buffer), .acc_to_fifo(acc_to_fifo)
   );

   caf_can_node u_node (
      .pclk(pclk), .presetn(presetn), .send(send), .sid(sid), .eid(eid), .ext(ext),
      .frm_ready(frm_ready), .frm_valid(frm_valid), .frm_std_id(frm_std_id),
      .frm_ext_id(frm_ext_id), .frm_is_ext(frm_is_ext)
   );

   // ========================================
   // Reporting
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want)
      begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Hang guard, a full run needs well under a quarter of this
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         close_out();
      end
   end

   // ========================================
   // Bus tasks: request held until pready is seen high at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
         output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 40)
      begin
         @(posedge pclk);
         k++;
      end
      r = prdata;
      e = pslverr;
      check(32'(pready), 32'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      check(32'(e), 32'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] want, input logic werr);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 16'h0000, r, e);
      check(r, want);
      check(32'(e), 32'(werr));
   endtask

   // ========================================
   // Reference match of one filter against a frame
   function automatic logic hit_of(int n, logic [10:0] s, logic [17:0] x, logic t);
      logic [1:0] src;
      logic [15:0] ms;
      src = msel[2*n +: 2];
      if (src == 2'h3 || !en[n])
         return 1'b0;
      ms = mm_std[src];
      if (ms[3] && mf_std[n][3] != t)
         return 1'b0;
      if (((s ^ mf_std[n][15:5]) & ms[15:5]) != 11'h000)
         return 1'b0;
      return !t || (((x ^ {mf_std[n][1:0], mf_ext[n]}) & {ms[1:0], mm_ext[src]}) == 18'h0);
   endfunction

   // One frame: result, its latency and the status word
   task automatic frame(input logic [10:0] s, input logic [17:0] x, input logic t);
      int k;
      int w;
      logic h;
      logic [3:0] f;
      logic [3:0] b;
      @(posedge pclk);
      send <= 1'b1;
      sid <= s;
      eid <= x;
      ext <= t;
      w = 16;
      for (int n = 15; n >= 0; n--)
         if (hit_of(n, s, x, t))
            w = n;
      h = (w < 16);
      f = h ? 4'(w) : 4'h0;
      b = h ? bptr[4*f +: 4] : 4'h0;
      @(posedge pclk);
      send <= 1'b0;
      k = 0;
      while (acc_valid !== 1'b1 && k < 40)
      begin
         @(posedge pclk);
         k++;
      end
      // Counted from the edge after send: node raises valid, port takes it, result launches
      check(32'(k), h ? 32'(w + 3) : 32'(NUM_FILTERS + 2));
      check({acc_hit, acc_filter, acc_buffer, acc_to_fifo}, {h, f, b, h && b == 4'hF});
      rd(ADDR_STATUS, {20'h0, b, f, 2'b00, h, 1'b0}, 1'b0);
   endtask

   // ========================================
   // Main sequence
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_MSEL_LOW, 32'h0, 1'b0);
      rd(ADDR_MSEL_HIGH, 32'h0, 1'b0);
      for (int m = 0; m < 3; m++)
      begin
         rd(ADDR_MASK_BASE + 12'(8*m), 32'h0, 1'b0);
         rd(ADDR_MASK_BASE + 12'(8*m + 4), 32'h0, 1'b0);
      end
      rd(12'h0FC, 32'h0, 1'b1);
      rd(12'h002, 32'h0, 1'b1);
      wr(ADDR_FILT_BASE, 16'hFFFF);
      rd(ADDR_FILT_BASE, 32'h0000FFEB, 1'b0);
      wr(ADDR_MASK_BASE, 16'hFFFF);
      rd(ADDR_MASK_BASE, 32'h0000FFEB, 1'b0);
      $display("Test registers done");
      // Filters: both types, all four mask source codes
      mm_std = '{16'hFFEB, 16'hFFE0, 16'hF00B};
      mm_ext = '{16'hFFFF, 16'h0000, 16'h00FF};
      msel = 32'hE4E4E4E4;
      for (int n = 0; n < 16; n++)
      begin
         mf_std[n] = {11'(n * 37 + 5), 1'b0, 1'(n), 1'b0, 2'(n)};
         mf_ext[n] = 16'(n * 4099 + 1);
         wr(ADDR_FILT_BASE + 12'(8*n), mf_std[n]);
         wr(ADDR_FILT_BASE + 12'(8*n + 4), mf_ext[n]);
      end
      for (int n = 0; n < 16; n++)
         rd(ADDR_FILT_BASE + 12'(8*n), {16'h0000, mf_std[n]}, 1'b0);
      for (int m = 0; m < 3; m++)
      begin
         wr(ADDR_MASK_BASE + 12'(8*m), mm_std[m]);
         wr(ADDR_MASK_BASE + 12'(8*m + 4), mm_ext[m]);
         rd(ADDR_MASK_BASE + 12'(8*m + 4), {16'h0000, mm_ext[m]}, 1'b0);
      end
      wr(ADDR_MSEL_LOW, msel[15:0]);
      wr(ADDR_MSEL_HIGH, msel[31:16]);
      rd(ADDR_MSEL_HIGH, {16'h0000, msel[31:16]}, 1'b0);
      // Exact, wrong type, sid bit 0, eid bit 8 and eid bit 17 variants
      for (int p = 0; p < 2; p++)
      begin
         en <= p ? 16'h5A5A : 16'hFFFF;
         for (int n = 0; n < 16; n++)
            for (int v = 0; v < 5; v++)
            begin
               vs = mf_std[n][15:5] ^ 11'(v == 2);
               vx = {mf_std[n][1:0], mf_ext[n]} ^ (v == 3 ? 18'h00100 : 18'h0);
               vx = vx ^ (v == 4 ? 18'h20000 : 18'h0);
               frame(vs, vx, mf_std[n][3] ^ (v == 1));
            end
      end
      $display("Test frames done");
      close_out();
   end
endmodule
